// ===== hw/sad_decoder.sv
// System address decoder for the nested superset physical address map.
// Function
// [R1] Widened map: 8 DRAM, 4 I/O, 3 reserved, 1 previous.
// [R2] Narrower map kept whole at lowest addresses.
// [R3] Each DRAM location has one address only.
// [R4] Unfitted DRAM partition answers with bus error.
// [R5] Enabled DRAM hole answers with bus error.
// [R6] Internal DRAM address subtracts per-region high offset.
// [R7] Empty space is ignored or bus error, no alias.
// [R8] Boot ROM covers low or high reset vector.
// [R9] Boot memory decoded inside the 32-bit space.
// [R10] Static peripherals decoded inside the 32-bit space.
// [R11] Significant DRAM decoded inside the 32-bit space.
// [R12] Same decode for every master.
// [R13] Shared resources have no alias addresses; the boot ROM answers at both reset vectors when HIGH_VECTOR_SELECT is set.
// [R14] No private window overlaps global addresses.
// [R15] Holes sit at start of higher DRAM regions.
// [R16] Fitted DRAM fills lowest regions first.
// [R17] 32-bit map: ROM, static I/O, mapped I/O, DRAM.
// [R18] Errors answered in-transaction with no target.
// [R19] Region type given for every decoded address.
module sad_decoder #(
    parameter int MAP_LEVELS = 4
) (
    // Clock and synchronous active-low reset.
    input wire logic CLK,
    input wire logic NRST,
    // Static configuration of the fitted system.
    input wire logic BOOT_ROM_FITTED,
    input wire logic HIGH_VECTOR_SELECT,
    input wire logic HOLE_EN,
    input wire logic EMPTY_ERR_EN,
    input wire logic [MAP_LEVELS:0] DRAM_FITTED,
    // Request from a bus master.
    input wire logic REQ_VALID,
    input wire sad_pkg::sad_req_t REQ,
    // Decoded answer, one cycle after the request.
    output logic RSP_VALID,
    output sad_pkg::sad_rsp_t RSP
);

    // Registered answer valid flag and its next value.
    logic rsp_valid_q;
    logic rsp_valid_d;
    // Registered answer and its next value.
    sad_pkg::sad_rsp_t rsp_q;
    sad_pkg::sad_rsp_t rsp_d;

    // Decoded fields of the present request.
    sad_pkg::sad_region_t region;
    sad_pkg::sad_target_t target;
    logic empty;
    logic unfitted;
    logic [2:0] lvl;
    logic [sad_pkg::SAD_ADDR_W-1:0] dram_addr;

    // Decode the request address, starting from the widest map level.
    always_comb begin
        logic found;
        logic above;
        logic half;
        logic [3:0] nib;
        logic [31:0] a32;
        found = 1'b0;
        above = 1'b0;
        half = 1'b0;
        nib = sad_pkg::SAD_NIB_PREV;
        a32 = REQ.addr[31:0];
        lvl = 3'h0;
        region = sad_pkg::SAD_RGN_RESERVED;
        target = sad_pkg::SAD_TGT_NONE;
        empty = 1'b0;
        unfitted = 1'b0;
        // Find the widest level whose sixteenth is not the previous map.
        for (int k = sad_pkg::SAD_MAX_LEVELS; k >= 1; k--) begin
            if (k > MAP_LEVELS) begin
                // Bits beyond the configured map lie outside every region.
                if (REQ.addr[4*k+31 -: 4] != sad_pkg::SAD_NIB_PREV) begin
                    above = 1'b1;
                end
            end else if (!found && REQ.addr[4*k+31 -: 4] != sad_pkg::SAD_NIB_PREV) begin
                // A zero sixteenth hands over to the narrower map. (see [R2])
                found = 1'b1;
                lvl = 3'(k);
                nib = REQ.addr[4*k+31 -: 4];
                half = REQ.addr[4*k+27];
            end
        end
        if (above) begin
            // Space above the implemented map is empty. (see [R7])
            region = sad_pkg::SAD_RGN_RESERVED;
            empty = 1'b1;
        end else if (found) begin
            // Split of a widened level into its sixteenths. (see [R1])
            if (nib < sad_pkg::SAD_NIB_MIO_FIRST) begin
                // Three reserved sixteenths decode to nothing. (see [R7])
                region = sad_pkg::SAD_RGN_RESERVED;
                empty = 1'b1;
            end else if (nib < sad_pkg::SAD_NIB_DRAM_FIRST) begin
                // Four sixteenths of mapped I/O.
                region = sad_pkg::SAD_RGN_MAPPED_IO;
                target = sad_pkg::SAD_TGT_MAPPED_IO;
            end else if (nib == sad_pkg::SAD_NIB_DRAM_FIRST && !half && HOLE_EN) begin
                // Hole at the start of the DRAM region. (see [R5]) (see [R15])
                region = sad_pkg::SAD_RGN_HOLE;
            end else begin
                // Eight sixteenths of DRAM, gated by its fitted flag. (see [R4])
                region = sad_pkg::SAD_RGN_DRAM;
                unfitted = !DRAM_FITTED[lvl];
                target = sad_pkg::SAD_TGT_DRAM;
            end
        end else if (HIGH_VECTOR_SELECT && a32 >= sad_pkg::SAD_HIGH_VEC_BASE) begin
            // High vector page takes the top of the 32-bit DRAM. (see [R8])
            region = sad_pkg::SAD_RGN_STATIC_IO;
            target = sad_pkg::SAD_TGT_BOOT_ROM;
            empty = !BOOT_ROM_FITTED;
        end else if (a32 <= sad_pkg::SAD_BOOT_ROM_LIMIT) begin
            // Boot ROM at the low reset vector. (see [R8]) (see [R17])
            region = sad_pkg::SAD_RGN_STATIC_IO;
            target = sad_pkg::SAD_TGT_BOOT_ROM;
            empty = !BOOT_ROM_FITTED;
        end else if (a32 <= sad_pkg::SAD_STATIC_IO_LIMIT) begin
            // Boot RAM and static peripherals stay 32-bit. (see [R9]) (see [R10])
            region = sad_pkg::SAD_RGN_STATIC_IO;
            target = sad_pkg::SAD_TGT_STATIC_IO;
        end else if (a32 <= sad_pkg::SAD_MAPPED_IO_LIMIT) begin
            // Mapped I/O of the 32-bit map. (see [R17])
            region = sad_pkg::SAD_RGN_MAPPED_IO;
            target = sad_pkg::SAD_TGT_MAPPED_IO;
        end else begin
            // Two gigabytes of 32-bit DRAM, the first to be fitted. (see [R11]) (see [R16])
            region = sad_pkg::SAD_RGN_DRAM;
            unfitted = !DRAM_FITTED[0];
            target = sad_pkg::SAD_TGT_DRAM;
        end
        if (empty || unfitted || region == sad_pkg::SAD_RGN_HOLE) begin
            // Nothing real is selected for a refused access. (see [R18])
            target = sad_pkg::SAD_TGT_NONE;
        end
    end

    // Form the internal address seen by the single DRAM device.
    always_comb begin
        if (HOLE_EN) begin
            // Offsets fold all regions onto one device. (see [R6]) (see [R3])
            dram_addr = REQ.addr - sad_pkg::SAD_DRAM_OFFSET[lvl];
        end else begin
            // Without holes the physical address is passed flat. (see [R3])
            dram_addr = REQ.addr;
        end
    end

    // Build the next answer; the master identity never alters the decode.
    always_comb begin
        rsp_valid_d = REQ_VALID;
        rsp_d = rsp_q;
        if (REQ_VALID) begin
            // Region type for every decoded address. (see [R19])
            rsp_d.region = region;
            rsp_d.target = target;
            // Internal address only for a routed DRAM access.
            if (target == sad_pkg::SAD_TGT_DRAM) begin
                rsp_d.dram_addr = dram_addr;
            end else begin
                rsp_d.dram_addr = '0;
            end
            // Empty space errors or is ignored as configured. (see [R7])
            rsp_d.error = (empty && EMPTY_ERR_EN) || unfitted
                || region == sad_pkg::SAD_RGN_HOLE; // see [R4] see [R5] see [R18]
            rsp_d.ignore = empty && !EMPTY_ERR_EN;
            rsp_d.write = REQ.write;
            // One global map for all masters, with no private window. (see [R12]) (see [R14])
            rsp_d.master = REQ.master;
        end
    end

    // Register the answer.
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            rsp_valid_q <= 1'b0;
            rsp_q <= '{region: sad_pkg::SAD_RGN_RESERVED, target: sad_pkg::SAD_TGT_NONE,
                       default: '0};
        end else begin
            rsp_valid_q <= rsp_valid_d;
            rsp_q <= rsp_d;
        end
    end

    // The answer leaves straight from the flip-flops.
    assign RSP_VALID = rsp_valid_q;
    assign RSP = rsp_q;

    // Checks on the decode, all on the one clock.
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!NRST);

    // Every request is answered on the next edge.
    a_answer_next: assert property (REQ_VALID |=> RSP_VALID) // see [R18]
        else $error("Request not answered on next cycle.");

    // A refused answer selects no target.
    a_error_no_target: assert property ( // see [R18]
        RSP_VALID && (RSP.error || RSP.ignore) |-> RSP.target == sad_pkg::SAD_TGT_NONE)
        else $error("Refused access still selects a target.");

    // An enabled hole always errors.
    a_hole_error: assert property ( // see [R5]
        RSP_VALID && RSP.region == sad_pkg::SAD_RGN_HOLE |-> RSP.error)
        else $error("Hole access did not error.");

    // Empty space follows the configured handling.
    a_empty_mode: assert property ( // see [R7]
        RSP_VALID && RSP.region == sad_pkg::SAD_RGN_RESERVED
        |-> RSP.error == $past(EMPTY_ERR_EN) && RSP.ignore == !$past(EMPTY_ERR_EN))
        else $error("Empty space handling wrong.");

    // Reserved sixteenths of the 36-bit level decode as reserved.
    a_reserved_split: assert property ( // see [R1]
        REQ_VALID && REQ.addr[47:36] == 12'h000 && REQ.addr[35:32] inside {[4'h1:4'h3]}
        |=> RSP.region == sad_pkg::SAD_RGN_RESERVED)
        else $error("Reserved sixteenth misdecoded.");

    // The 32-bit mapped I/O window is kept at the bottom.
    a_low_mapped_io: assert property ( // see [R2]
        REQ_VALID && REQ.addr[47:30] == 18'h00001
        |=> RSP.region == sad_pkg::SAD_RGN_MAPPED_IO && RSP.target == sad_pkg::SAD_TGT_MAPPED_IO)
        else $error("32-bit mapped I/O misdecoded.");

    // The low reset vector reaches a fitted boot ROM.
    a_low_vector: assert property ( // see [R8]
        REQ_VALID && BOOT_ROM_FITTED && REQ.addr[47:16] == 32'h0000_0000
        |=> RSP.target == sad_pkg::SAD_TGT_BOOT_ROM && !RSP.error && !RSP.ignore)
        else $error("Low vector missed the boot ROM.");

    // The high vector page reaches boot ROM only when selected.
    a_high_vector: assert property ( // see [R8]
        REQ_VALID && BOOT_ROM_FITTED && REQ.addr[47:16] == 32'h0000_FFFF
        |=> (RSP.target == sad_pkg::SAD_TGT_BOOT_ROM) == $past(HIGH_VECTOR_SELECT))
        else $error("High vector page misrouted.");

    // Unfitted DRAM in the 32-bit map errors.
    a_unfitted_dram: assert property ( // see [R4]
        REQ_VALID && !DRAM_FITTED[0] && REQ.addr[47:31] == 17'h00001 && !HIGH_VECTOR_SELECT
        |=> RSP.error && RSP.region == sad_pkg::SAD_RGN_DRAM)
        else $error("Unfitted DRAM not refused.");

    // The 32-bit DRAM folds to the bottom of the device.
    a_dram_offset: assert property ( // see [R6]
        RSP_VALID && RSP.target == sad_pkg::SAD_TGT_DRAM && $past(HOLE_EN)
        && $past(REQ.addr[47:32]) == 16'h0000
        |-> RSP.dram_addr == $past(REQ.addr) - 48'h0000_8000_0000)
        else $error("32-bit DRAM offset wrong.");

    // The 36-bit DRAM region follows the 32-bit one inside the device.
    a_dram_offset36: assert property ( // see [R6]
        REQ_VALID && HOLE_EN && DRAM_FITTED[1] && REQ.addr[47:31] == 17'h00011
        |=> RSP.target == sad_pkg::SAD_TGT_DRAM
        && RSP.dram_addr == $past(REQ.addr) - 48'h0008_0000_0000)
        else $error("36-bit DRAM offset wrong.");

    // The answer carries the master and the write flag of its request.
    a_master_kept: assert property ( // see [R12]
        REQ_VALID |=> RSP.master == $past(REQ.master) && RSP.write == $past(REQ.write))
        else $error("Master or direction not carried.");

endmodule : sad_decoder

// ===== hw/sad_pkg.sv
// Package with the address map constants and the request and answer carriers.
package sad_pkg;

    // Width of the widest physical address that the decoder accepts.
    localparam int SAD_ADDR_W = 48;
    // Number of map levels above the 32-bit map that fit in the address.
    localparam int SAD_MAX_LEVELS = 4;
    // Width of the master identifier carried with each request.
    localparam int SAD_MASTER_W = 8;

    // Last address of the boot ROM window at the bottom of the 32-bit map.
    localparam logic [31:0] SAD_BOOT_ROM_LIMIT = 32'h0000_FFFF;
    // Last address of the static I/O and static memory window.
    localparam logic [31:0] SAD_STATIC_IO_LIMIT = 32'h3FFF_FFFF;
    // Last address of the mapped I/O window of the 32-bit map.
    localparam logic [31:0] SAD_MAPPED_IO_LIMIT = 32'h7FFF_FFFF;
    // First address of the high reset vector page.
    localparam logic [31:0] SAD_HIGH_VEC_BASE = 32'hFFFF_0000;

    // Sixteenth codes of a widened map: 0 is the previous map.
    localparam logic [3:0] SAD_NIB_PREV = 4'h0;
    // First sixteenth of mapped I/O; the three below it are reserved.
    localparam logic [3:0] SAD_NIB_MIO_FIRST = 4'h4;
    // First sixteenth of DRAM; the lower half of it may be a hole.
    localparam logic [3:0] SAD_NIB_DRAM_FIRST = 4'h8;

    // Amount taken off the high bits to form the internal DRAM address, per level.
    localparam logic [SAD_ADDR_W-1:0] SAD_DRAM_OFFSET [0:SAD_MAX_LEVELS] = '{
        48'h0000_8000_0000,
        48'h0008_0000_0000,
        48'h0080_0000_0000,
        48'h0800_0000_0000,
        48'h8000_0000_0000
    };

    // Kind of region that an address falls in.
    typedef enum logic [2:0] {
        SAD_RGN_STATIC_IO,
        SAD_RGN_MAPPED_IO,
        SAD_RGN_DRAM,
        SAD_RGN_HOLE,
        SAD_RGN_RESERVED
    } sad_region_t;

    // Target that the access is routed to.
    typedef enum logic [2:0] {
        SAD_TGT_NONE,
        SAD_TGT_BOOT_ROM,
        SAD_TGT_STATIC_IO,
        SAD_TGT_MAPPED_IO,
        SAD_TGT_DRAM
    } sad_target_t;

    // Request presented by a bus master.
    typedef struct packed {
        logic [SAD_ADDR_W-1:0] addr;
        logic write;
        logic [SAD_MASTER_W-1:0] master;
    } sad_req_t;

    // Decoded answer for one request.
    typedef struct packed {
        sad_region_t region;
        sad_target_t target;
        logic [SAD_ADDR_W-1:0] dram_addr;
        logic error;
        logic ignore;
        logic write;
        logic [SAD_MASTER_W-1:0] master;
    } sad_rsp_t;

endpackage : sad_pkg

// ===== tb/sad_target_model.sv
// Target side model that counts the accesses that the decoder routes to the DRAM and to the boot ROM, and stray ones.
module sad_target_model (
    // Clock and reset.
    input wire logic clk,
    input wire logic nrst,
    // Decoded answer from the decoder.
    input wire logic rsp_valid,
    input wire sad_pkg::sad_rsp_t rsp,
    // Counts seen by the targets.
    output logic [15:0] dram_hits,
    output logic [15:0] rom_hits,
    output logic [15:0] stray_hits
);
    timeunit 1ns;
    timeprecision 1ps;

    // Counters start at zero and survive a reset of the decoder.
    initial begin
        dram_hits = 16'h0000;
        rom_hits = 16'h0000;
        stray_hits = 16'h0000;
    end

    // A target only takes an access that is neither an error nor dropped.
    always @(posedge clk) begin
        if (nrst && rsp_valid) begin
            if ((rsp.error || rsp.ignore) && rsp.target != sad_pkg::SAD_TGT_NONE) begin
                stray_hits <= stray_hits + 16'h0001;
            end else if (rsp.target == sad_pkg::SAD_TGT_DRAM) begin
                dram_hits <= dram_hits + 16'h0001;
            end else if (rsp.target == sad_pkg::SAD_TGT_BOOT_ROM) begin
                rom_hits <= rom_hits + 16'h0001;
            end
        end
    end
endmodule : sad_target_model

// ===== tb/tb_top.sv
// Self-checking testbench for the system address decoder.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    // Design inputs and outputs.
    logic CLK = 1'b0;
    logic NRST = 1'b0;
    logic BOOT_ROM_FITTED = 1'b0;
    logic HIGH_VECTOR_SELECT = 1'b0;
    logic HOLE_EN = 1'b0;
    logic EMPTY_ERR_EN = 1'b0;
    logic [4:0] DRAM_FITTED = 5'h00;
    logic REQ_VALID = 1'b0;
    sad_pkg::sad_req_t REQ = '0;
    logic RSP_VALID;
    sad_pkg::sad_rsp_t RSP;
    // Partner counts and bench bookkeeping.
    logic [15:0] dram_hits, rom_hits, stray_hits;
    sad_pkg::sad_rsp_t exp_q [$];
    int fail_count = 0;
    int samples_checked = 0;
    int exp_dram = 0;
    int exp_rom = 0;
    logic [31:0] seed = 32'h68688588;
    // Address corners of every map level except the 44-bit one.
    logic [47:0] corners [16] = '{48'h0, 48'hFFFF, 48'h1_0000, 48'h3FFF_FFFF, 48'h4000_0000,
        48'h7FFF_FFFF, 48'h8000_1000, 48'hFFFE_FFFF, 48'hFFFF_0000, 48'h8_0000_0000,
        48'h8_8000_0000, 48'h1_0000_0000, 48'h4_0000_0000, 48'h80_0000_0000,
        48'h8000_0000_0000, 48'hFFFF_FFFF_FFFF};

    sad_decoder sad_decoder_inst (.CLK(CLK), .NRST(NRST), .BOOT_ROM_FITTED(BOOT_ROM_FITTED),
        .HIGH_VECTOR_SELECT(HIGH_VECTOR_SELECT), .HOLE_EN(HOLE_EN),
        .EMPTY_ERR_EN(EMPTY_ERR_EN), .DRAM_FITTED(DRAM_FITTED), .REQ_VALID(REQ_VALID),
        .REQ(REQ), .RSP_VALID(RSP_VALID), .RSP(RSP));

    sad_target_model sad_target_model_inst (.clk(CLK), .nrst(NRST), .rsp_valid(RSP_VALID),
        .rsp(RSP), .dram_hits(dram_hits), .rom_hits(rom_hits), .stray_hits(stray_hits));

    // Free running 100 MHz clock.
    initial begin
        forever #5 CLK = ~CLK;
    end

    // Reports one comparison and counts it.
    task automatic check(input string what, input logic [79:0] seen, input logic [79:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Works out the answer from the map; c is {fitted, empty err, hole, high vec, rom}.
    function automatic sad_pkg::sad_rsp_t exp_of(sad_pkg::sad_req_t q, logic [8:0] c);
        sad_pkg::sad_rsp_t r;
        int lev;
        logic [3:0] nib;
        logic empty;
        r = '0;
        r.write = q.write;
        r.master = q.master;
        r.region = sad_pkg::SAD_RGN_RESERVED;
        lev = 0;
        nib = 4'h0;
        empty = 1'b0;
        for (int k = 1; k <= 4; k++) begin
            if (q.addr[4*k+28 +: 4] != 4'h0) begin
                lev = k;
                nib = q.addr[4*k+28 +: 4];
            end
        end
        if (lev > 0 && nib < 4'h4) begin
            empty = 1'b1;
        end else if (lev > 0 && nib < 4'h8) begin
            r.region = sad_pkg::SAD_RGN_MAPPED_IO;
            r.target = sad_pkg::SAD_TGT_MAPPED_IO;
        end else if (lev > 0 && nib == 4'h8 && !q.addr[4*lev+27] && c[2]) begin
            r.region = sad_pkg::SAD_RGN_HOLE;
            r.error = 1'b1;
        end else if (lev == 0 && ((c[1] && q.addr[31:16] == 16'hFFFF) ||
                     q.addr[31:0] <= sad_pkg::SAD_BOOT_ROM_LIMIT)) begin
            r.region = sad_pkg::SAD_RGN_STATIC_IO;
            r.target = c[0] ? sad_pkg::SAD_TGT_BOOT_ROM : sad_pkg::SAD_TGT_NONE;
            empty = !c[0];
        end else if (lev == 0 && q.addr[31:0] <= sad_pkg::SAD_STATIC_IO_LIMIT) begin
            r.region = sad_pkg::SAD_RGN_STATIC_IO;
            r.target = sad_pkg::SAD_TGT_STATIC_IO;
        end else if (lev == 0 && q.addr[31:0] <= sad_pkg::SAD_MAPPED_IO_LIMIT) begin
            r.region = sad_pkg::SAD_RGN_MAPPED_IO;
            r.target = sad_pkg::SAD_TGT_MAPPED_IO;
        end else begin
            r.region = sad_pkg::SAD_RGN_DRAM;
            r.error = !c[4+lev];
            if (c[4+lev]) begin
                r.target = sad_pkg::SAD_TGT_DRAM;
                r.dram_addr = c[2] ? q.addr - sad_pkg::SAD_DRAM_OFFSET[lev] : q.addr;
            end
        end
        if (empty) begin
            r.error = c[3];
            r.ignore = !c[3];
        end
        return r;
    endfunction : exp_of

    // Presents one request with its configuration and notes the expected answer.
    task automatic send(input logic [47:0] a, input logic [8:0] c);
        sad_pkg::sad_req_t q;
        logic [31:0] rv;
        sad_pkg::sad_rsp_t e;
        rv = $random(seed);
        q.addr = a;
        q.write = rv[0];
        q.master = rv[8:1];
        e = exp_of(q, c);
        @(posedge CLK);
        REQ_VALID <= 1'b1;
        REQ <= q;
        {DRAM_FITTED, EMPTY_ERR_EN, HOLE_EN, HIGH_VECTOR_SELECT, BOOT_ROM_FITTED} <= c;
        exp_q.push_back(e);
        exp_dram += (e.target == sad_pkg::SAD_TGT_DRAM);
        exp_rom += (e.target == sad_pkg::SAD_TGT_BOOT_ROM);
    endtask : send

    // Drops the request strobe at the next edge.
    task automatic idle();
        @(posedge CLK);
        REQ_VALID <= 1'b0;
    endtask : idle

    // Takes the oldest note whenever an answer appears, once it has settled.
    always @(negedge CLK) begin
        if (RSP_VALID === 1'b1) begin
            if (exp_q.size() == 0) begin
                check("unexpected answer", 80'h1, 80'h0);
            end else begin
                check("answer", 80'(RSP), 80'(exp_q.pop_front()));
            end
        end
    end

    // Prints the counts and the verdict, then stops.
    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_sim

    // Cuts a hang short well after the expected run time.
    initial begin
        #500000;
        fail_count++;
        end_sim();
    end

    // Main sequence: corners back to back, reset mid-run, then random traffic.
    initial begin
        logic [8:0] c;
        logic [47:0] a;
        logic [31:0] r32;
        int lev;
        repeat (6) @(posedge CLK);
        NRST <= 1'b1;
        for (int i = 0; i < 16; i++) begin
            c = {(i[0] ? 5'h1F : 5'h0A), i[3:0]};
            c[1] = c[1] & c[0];
            foreach (corners[j]) send(corners[j], c);
        end
        idle();
        repeat (3) @(posedge CLK);
        NRST <= 1'b0;
        @(posedge CLK);
        #1;
        check("valid in reset", 80'(RSP_VALID), 80'h0);
        check("region in reset", 80'(RSP.region), 80'(sad_pkg::SAD_RGN_RESERVED));
        NRST <= 1'b1;
        for (int n = 0; n < 1500; n++) begin
            r32 = $random(seed);
            lev = r32[10:8] % 5;
            a = 48'({$random(seed), $random(seed)});
            if (lev > 0) begin
                a = (a & ((48'h1 << (4*lev+28)) - 48'h1)) | (48'(r32[7:4]) << (4*lev+28));
            end
            c = 9'($random(seed));
            c[1] = c[1] & c[0];
            send(a, c);
            if (r32[12]) idle();
        end
        idle();
        repeat (4) @(posedge CLK);
        check("queue left", 80'(exp_q.size()), 80'h0);
        check("dram hits", 80'(dram_hits), 80'(exp_dram));
        check("rom hits", 80'(rom_hits), 80'(exp_rom));
        check("stray hits", 80'(stray_hits), 80'h0);
        end_sim();
    end
endmodule : tb_top
